// ==== hw/ocu_compare.sv ====
// Output compare channel: register file, mode engine and compare pin drive.
// Assumes timer_count and timer_tick come from a timebase on the same clock,
// and that software stops that timebase while rewriting the control register.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module ocu_compare
  import ocu_pkg::*;
#(
  parameter int CHANNEL = 1,
  parameter int TW = ocu_pkg::TIMER_W,
  parameter int NPIN = ocu_pkg::NUM_RPIN
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [ocu_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ocu_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ocu_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [TW-1:0] timer_count,
  input wire logic timer_tick,
  input wire logic [NPIN-1:0] remappable_pin,
  output logic compare_output_pin,
  output logic compare_output_pin_oe,
  output logic compare_event,
  output logic dma_req
);
  import ocu_pkg::*;

  localparam logic DMA_OK = (CHANNEL >= 1) && (CHANNEL <= DMA_MAX_CHANNEL);
  localparam logic FAULT_EVT_OK = (CHANNEL >= 1) && (CHANNEL <= FAULT_MAX_CHANNEL);

  typedef struct packed {
    ocu_mode_t mode;
    logic fault_flag;
    logic pin;
    logic oe;
    logic done;
    logic [TW-1:0] primary;
    logic [TW-1:0] secondary;
    logic [FSEL_W-1:0] fsel;
    logic [DATA_W-1:0] rdata;
    logic event_p;
  } ocu_state_t;

  ocu_state_t st_reg;
  ocu_state_t st_next;

  ocu_fault_if fault_bus ();

  ocu_fault_sync #(
    .NPIN(NPIN)
  ) u_fault_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .remappable_pin(remappable_pin),
    .fault(fault_bus.sync)
  );

  assign fault_bus.sel = st_reg.fsel;

  logic wr_ctrl;
  logic hit_p;
  logic hit_s;
  logic period_start;
  logic fault_hit;

  assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  assign hit_p = timer_tick && (timer_count == st_reg.primary);
  assign hit_s = timer_tick && (timer_count == st_reg.secondary);
  assign period_start = timer_tick && (timer_count == '0);
  assign fault_hit = fault_bus.fall && (st_reg.mode == MODE_PWM_FAULT);

  function automatic logic [DATA_W-1:0] widen(input logic [TW-1:0] v);
    logic [DATA_W-1:0] w;
    w = '0;
    w[TW-1:0] = v;
    return w;
  endfunction : widen

  always_comb begin
    st_next = st_reg;
    st_next.event_p = 1'b0;
    st_next.rdata = '0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_PRIMARY: st_next.primary = reg_wdata[TW-1:0];
        ADDR_SECONDARY: st_next.secondary = reg_wdata[TW-1:0];
        ADDR_FAULT_SEL: st_next.fsel = reg_wdata[FSEL_W-1:0];
        default: ;
      endcase
    end
    if (wr_ctrl) begin
      // Entry into a mode sets the starting level and rearms one-shots
      st_next.mode = ocu_mode_t'(reg_wdata[MODE_LSB +: MODE_W]);
      st_next.fault_flag = 1'b0;
      st_next.done = 1'b0;
      st_next.oe = 1'b1;
      case (ocu_mode_t'(reg_wdata[MODE_LSB +: MODE_W]))
        MODE_OFF: begin
          st_next.oe = 1'b0;
          st_next.pin = 1'b0;
        end
        MODE_LOW_SHOT: st_next.pin = 1'b0;
        MODE_HIGH_SHOT: st_next.pin = 1'b1;
        MODE_TOGGLE: st_next.pin = st_reg.pin;
        MODE_DELAY_SHOT: st_next.pin = 1'b0;
        MODE_CONT_PULSE: st_next.pin = 1'b0;
        MODE_PWM, MODE_PWM_FAULT: st_next.pin = (st_reg.primary != '0);
        default: st_next.pin = 1'b0;
      endcase
    end else begin
      case (st_reg.mode)
        MODE_LOW_SHOT: begin
          if (!st_reg.done && hit_p) begin
            st_next.pin = 1'b1;
            st_next.done = 1'b1;
            st_next.event_p = 1'b1;
          end
        end
        MODE_HIGH_SHOT: begin
          if (!st_reg.done && hit_p) begin
            st_next.pin = 1'b0;
            st_next.done = 1'b1;
            st_next.event_p = 1'b1;
          end
        end
        MODE_TOGGLE: begin
          if (hit_p) begin
            st_next.pin = !st_reg.pin;
            st_next.event_p = 1'b1;
          end
        end
        MODE_DELAY_SHOT, MODE_CONT_PULSE: begin
          // Primary match raises the pulse, secondary match ends it
          if (!st_reg.done && !st_reg.pin && hit_p) begin
            st_next.pin = 1'b1;
          end else if (!st_reg.done && st_reg.pin && hit_s) begin
            st_next.pin = 1'b0;
            st_next.event_p = 1'b1;
            st_next.done = (st_reg.mode == MODE_DELAY_SHOT);
          end
        end
        MODE_PWM, MODE_PWM_FAULT: begin
          // Period starts at count zero; a zero duty keeps the pin low
          if (!st_reg.fault_flag) begin
            if (period_start) begin
              st_next.pin = (st_reg.primary != '0);
            end
            if (hit_p) begin
              st_next.pin = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
    // A fault landing on a control write still latches: set beats clear
    if (fault_hit) begin
      st_next.fault_flag = 1'b1;
      st_next.pin = 1'b0;
      st_next.event_p = FAULT_EVT_OK;
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: begin
          st_next.rdata[MODE_LSB +: MODE_W] = st_reg.mode;
          st_next.rdata[FAULT_FLAG_BIT] = st_reg.fault_flag;
        end
        ADDR_PRIMARY: st_next.rdata = widen(st_reg.primary);
        ADDR_SECONDARY: st_next.rdata = widen(st_reg.secondary);
        ADDR_FAULT_SEL: st_next.rdata[FSEL_W-1:0] = st_reg.fsel;
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg <= '{mode: MODE_OFF, fault_flag: 1'b0, pin: 1'b0, oe: 1'b0, done: 1'b0,
                  primary: '0, secondary: '0, fsel: FSEL_RESET, rdata: '0,
                  event_p: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign compare_output_pin = st_reg.pin;
  assign compare_output_pin_oe = st_reg.oe;
  assign compare_event = st_reg.event_p;
  // DMA requests are wired out only for the low channels
  assign dma_req = st_reg.event_p && DMA_OK;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_mode_write(logic [MODE_W-1:0] m);
    wr_ctrl && !fault_hit && reg_wdata[MODE_LSB +: MODE_W] == m;
  endsequence

  sequence s_pulse_armed;
    st_reg.mode == MODE_DELAY_SHOT && !wr_ctrl && !fault_hit && hit_p && !st_reg.pin
      && !st_reg.done;
  endsequence

  a_off_release: assert property (s_mode_write(3'h0) |=> !compare_output_pin_oe
                                   until wr_ctrl)
    else $error("pin still driven with channel disabled");
  a_low_shot: assert property (compare_event && st_reg.mode == MODE_LOW_SHOT
                               |-> $rose(compare_output_pin))
    else $error("low one-shot event without rising pin");
  a_high_start: assert property (s_mode_write(3'h2) |=> compare_output_pin
                                 && compare_output_pin_oe)
    else $error("high one-shot did not start high");
  a_toggle_keep: assert property (s_mode_write(3'h3) |=>
                                  compare_output_pin == $past(compare_output_pin))
    else $error("toggle entry changed the pin");
  a_delay_pulse: assert property (s_pulse_armed ##1 (!wr_ctrl && hit_s && !fault_hit)
                                  |=> !compare_output_pin && compare_event)
    else $error("delayed pulse did not end with an event");
  a_cont_fall: assert property (compare_event && st_reg.mode == MODE_CONT_PULSE
                                |-> $fell(compare_output_pin))
    else $error("continuous pulse event without falling pin");
  a_pwm_start: assert property (s_mode_write(3'h6) |=>
                                compare_output_pin == (st_reg.primary != '0)
                                && !compare_event)
    else $error("pwm start level wrong");
  a_pwm_quiet: assert property (st_reg.mode == MODE_PWM && $stable(st_reg.mode)
                                |-> !compare_event)
    else $error("pwm without fault raised an event");
  a_fault_trip: assert property (fault_hit |=> !compare_output_pin
                                 && st_reg.fault_flag
                                 && compare_event == FAULT_EVT_OK)
    else $error("fault edge did not force the pin low");
  a_dma_gate: assert property (dma_req |-> compare_event && DMA_OK)
    else $error("dma request from a channel without dma");
  a_fsel_reset: assert property ($past(sys_rst) |-> st_reg.fsel == FSEL_RESET)
    else $error("fault select not all ones after reset");
  a_match_set: assert property (st_reg.mode == MODE_LOW_SHOT && !st_reg.done && hit_p
                                && !wr_ctrl |=> compare_output_pin ##1 compare_output_pin)
    else $error("primary match did not set the pin");
endmodule : ocu_compare
`default_nettype wire

// ==== hw/ocu_pkg.sv ====
// Constants, field layout and mode codes of the output compare unit.
// Assumes the timebase counter and its advance strobe run on the same clock.
//
// Notes on behaviour
// - Three-bit mode field selects the mode; 000 releases the pin to port logic.
// - Mode 001: pin starts low, event on the rising output edge.
// - Mode 010: pin starts high, event on the falling output edge.
// - Mode 011: present level kept on entry, event on every output edge.
// - Mode 100: pin starts low, event on the falling output edge.
// - Mode 101: pin starts low, event on each falling output edge, repeating.
// - Mode 110: pin starts low if primary is zero, else high; no event.
// - Mode 111: same start; fault input falling edge raises event on channels 1-4.
// - Only channels 1 and 2 ever request DMA.
// - Five-bit select routes fault input from pin n; 11111 grounds it; resets to ones.
package ocu_pkg;
  localparam int DATA_W = 16;
  localparam int TIMER_W = 16;
  localparam int ADDR_W = 2;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_PRIMARY = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_SECONDARY = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_FAULT_SEL = 2'h3;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int FAULT_FLAG_BIT = 4;
  localparam int FSEL_W = 5;
  localparam logic [FSEL_W-1:0] FSEL_RESET = 5'h1F;
  localparam logic [FSEL_W-1:0] FSEL_MAX_PIN = 5'h19;
  localparam int NUM_RPIN = 26;
  localparam int DMA_MAX_CHANNEL = 2;
  localparam int FAULT_MAX_CHANNEL = 4;
  typedef enum logic [MODE_W-1:0] {
    MODE_OFF = 3'h0,
    MODE_LOW_SHOT = 3'h1,
    MODE_HIGH_SHOT = 3'h2,
    MODE_TOGGLE = 3'h3,
    MODE_DELAY_SHOT = 3'h4,
    MODE_CONT_PULSE = 3'h5,
    MODE_PWM = 3'h6,
    MODE_PWM_FAULT = 3'h7
  } ocu_mode_t;
endpackage : ocu_pkg

// ==== hw/ocu_fault_if.sv ====
// Carries the fault pin selection and the filtered fault level between modules.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface ocu_fault_if;
  logic [ocu_pkg::FSEL_W-1:0] sel;
  logic level;
  logic fall;
  modport ctrl (output sel, input level, input fall);
  modport sync (input sel, output level, output fall);
endinterface : ocu_fault_if
`default_nettype wire

// ==== hw/ocu_fault_sync.sv ====
// Fault input routing: picks one remappable pin, synchronises and filters it.
// Assumes the pins are asynchronous and the select is held steady by software.
`timescale 1ns/1ns
`default_nettype none
module ocu_fault_sync
  import ocu_pkg::*;
#(
  parameter int NPIN = ocu_pkg::NUM_RPIN
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [NPIN-1:0] remappable_pin,
  ocu_fault_if.sync fault
);
  import ocu_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic stable;
    logic fall;
  } ocu_sync_t;

  ocu_sync_t sync_reg;
  ocu_sync_t sync_next;

  // Codes past the last pin, the ground code among them, read as low
  function automatic logic pick_pin(input logic [FSEL_W-1:0] sel,
                                    input logic [NPIN-1:0] pins);
    logic v;
    v = 1'b0;
    if (sel <= FSEL_MAX_PIN && int'(sel) < NPIN) begin
      v = pins[sel];
    end
    return v;
  endfunction : pick_pin

  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = pick_pin(fault.sel, remappable_pin);
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    sync_next.fall = 1'b0;
    // Only a level seen twice in a row counts, which rejects one-cycle glitches
    if (sync_reg.s2 == sync_reg.s3) begin
      sync_next.stable = sync_reg.s3;
      sync_next.fall = sync_reg.stable && !sync_reg.s3;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync_reg <= '{s1: 1'b0, s2: 1'b0, s3: 1'b0, stable: 1'b0, fall: 1'b0};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign fault.level = sync_reg.stable;
  assign fault.fall = sync_reg.fall;
endmodule : ocu_fault_sync
`default_nettype wire

// ==== dv/ocu_load_model.sv ====
// External load on the compare pin, plus the pins that feed the fault input.
// Assumes a pull-down on the compare pin while the unit is not driving it.
`timescale 1ns/1ns
`default_nettype none
module ocu_load_model (
  input wire logic pin,
  input wire logic pin_oe,
  input wire logic [25:0] pull_low,
  output logic line,
  output logic [25:0] rpin
);
  // A released pin falls to the pull-down, it never keeps the last value
  assign line = pin_oe ? pin : 1'b0;
  // Idle pins sit high so only a commanded drop looks like a fault
  assign rpin = ~pull_low;
endmodule : ocu_load_model
`default_nettype wire

// ==== dv/test_output_compare_unit.sv ====
// Self-checking bench for the output compare channel, channel 1.
// Assumes the timebase is modelled here and is stopped around control writes.
`timescale 1ns/1ns
`default_nettype none
module test_output_compare_unit;
  import ocu_pkg::*;
  logic clock, sys_rst, reg_wr, reg_rd, timer_tick;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rv;
  logic [15:0] timer_count;
  logic [25:0] rpin, pull_low;
  logic pin, pin_oe, compare_event, dma_req, line;
  int n_fail, num_checks, n_ev, n_dma, e0, d0;
  logic [0:6] st_tab = 7'b0100011;
  logic [0:6] end_tab = 7'b1000000;
  int ev_tab[7] = '{1, 1, 2, 1, 2, 0, 0};

  ocu_compare #(.CHANNEL(1)) u_dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_count(timer_count), .timer_tick(timer_tick), .remappable_pin(rpin),
    .compare_output_pin(pin), .compare_output_pin_oe(pin_oe),
    .compare_event(compare_event), .dma_req(dma_req));
  ocu_load_model u_load (.pin(pin), .pin_oe(pin_oe), .pull_low(pull_low), .line(line),
    .rpin(rpin));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    if (compare_event === 1'b1) n_ev <= n_ev + 1;
    if (dma_req === 1'b1) n_dma <= n_dma + 1;
  end

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask : rd

  task settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : settle

  // Two full sweeps of 0..15 so one-shots can prove they fire only once
  task run_timer();
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge clock);
        timer_count <= 16'(c);
        timer_tick <= 1'b1;
      end
    end
    @(posedge clock);
    // Timebase held still so the control writes that follow are safe
    timer_tick <= 1'b0;
    settle(3);
  endtask : run_timer

  task test_reset();
    rd(ADDR_CTRL, rv);
    chk("control", 16'h0000, rv);
    rd(ADDR_FAULT_SEL, rv);
    chk("fault select", 16'h001F, rv);
    chk("oe", 16'h0000, {15'h0000, pin_oe});
    wr(ADDR_CTRL, 16'hFFFE);
    rd(ADDR_CTRL, rv);
    chk("control masked", 16'h0006, rv);
    wr(ADDR_CTRL, 16'h0000);
    $display("reset test done");
  endtask : test_reset

  task test_modes();
    wr(ADDR_PRIMARY, 16'h0005);
    wr(ADDR_SECONDARY, 16'h0009);
    for (int m = 1; m < 8; m++) begin
      wr(ADDR_CTRL, 16'(m));
      settle(1);
      chk("start level", {15'h0000, st_tab[m-1]}, {15'h0000, line});
      chk("oe on", 16'h0001, {15'h0000, pin_oe});
      e0 = n_ev;
      d0 = n_dma;
      run_timer();
      chk("events", 16'(ev_tab[m-1]), 16'(n_ev - e0));
      chk("dma", 16'(ev_tab[m-1]), 16'(n_dma - d0));
      chk("end level", {15'h0000, end_tab[m-1]}, {15'h0000, line});
    end
    // Secondary right after primary: the pulse ends on the next tick
    wr(ADDR_SECONDARY, 16'h0006);
    wr(ADDR_CTRL, 16'h0004);
    settle(1);
    e0 = n_ev;
    run_timer();
    chk("short pulse events", 16'h0001, 16'(n_ev - e0));
    chk("short pulse end", 16'h0000, {15'h0000, line});
    wr(ADDR_CTRL, 16'h0000);
    settle(1);
    chk("released", 16'h0000, {14'h0000, pin_oe, line});
    $display("mode test done");
  endtask : test_modes

  task test_fault();
    wr(ADDR_FAULT_SEL, 16'h0003);
    wr(ADDR_CTRL, 16'h0006);
    e0 = n_ev;
    pull_low[3] <= 1'b1;
    settle(12);
    chk("fault ignored", 16'h0001, {15'h0000, line});
    chk("no event", 16'(e0), 16'(n_ev));
    pull_low[3] <= 1'b0;
    settle(12);
    wr(ADDR_CTRL, 16'h0007);
    settle(1);
    e0 = n_ev;
    d0 = n_dma;
    pull_low[3] <= 1'b1;
    for (int i = 0; i < 12 && n_ev == e0; i++) @(posedge clock);
    settle(1);
    chk("fault event", 16'h0001, 16'(n_ev - e0));
    chk("fault dma", 16'h0001, 16'(n_dma - d0));
    chk("fault pin", 16'h0000, {15'h0000, line});
    rd(ADDR_CTRL, rv);
    chk("fault flag", 16'h0017, rv);
    $display("fault test done");
  endtask : test_fault

  task stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    timer_count = '0;
    timer_tick = 1'b0;
    pull_low = '0;
    n_fail = 0;
    num_checks = 0;
    n_ev = 0;
    n_dma = 0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    test_reset();
    test_modes();
    test_fault();
    stop_test();
  end
endmodule : test_output_compare_unit
`default_nettype wire
